/* inc/timer_sync_pkg.sv */
// constants, modes and carriers of the timer trigger and synchronisation control
// Contract
// - With main output enable low, outputs settle at idle levels after dead-time.
// - Idle-level bits ignore writes while protection lock level is 1, 2 or 3.
// - Input 1 is channel pin 1, or XOR of pins 1..3 when selected.
// - Master code 000 sends update-generate pulse; slave-mode reset shows one cycle late.
// - Master code 001 sends counter-run: run bit OR gated trigger level.
// - Master code 010 sends the update event.
// - Master code 011 pulses whenever channel 1 capture flag is to be set.
// - Master codes 100..111 send compare reference of channel 0..3.
// - Channel DMA request on channel event, or on update when selected.
// - Preloaded enable/mode bits load on commutation: generate bit or trigger rise.
// - External trigger polarity bit inverts the external trigger pin when set.
// - External clock mode 2 counts filtered external trigger rising edges; it wins.
// - External trigger divider divides by 1, 2, 4 or 8.
// - Filter passes a transition after N equal samples at coded sample rate.
// - Master/slave sync bit delays trigger input effect by one cycle.
// - Trigger select picks inner triggers, input edges, filtered inputs or external.
// - Encoder modes count on input edges with direction from the other input.
// - Slave modes off, reset, gated, trigger and external clock 1 behave as coded.
// - Trigger flag sets on active trigger edge; both edges in gated mode.
// - Switchover flag sets whenever a commutation loads the channel control bits.
package timer_sync_pkg;
  // register map
  localparam logic [7:0] OFS_TRIG_OUT_CTRL = 8'h04;
  localparam logic [7:0] OFS_SLAVE_TRIG_CTRL = 8'h08;
  localparam logic [15:0] RST_TRIG_OUT_CTRL = 16'h0000;
  localparam logic [15:0] RST_SLAVE_TRIG_CTRL = 16'h0000;
  localparam logic [15:0] MASK_TRIG_OUT_CTRL = 16'h7ffd;
  localparam logic [15:0] MASK_SLAVE_TRIG_CTRL = 16'hfff7;
  localparam logic [15:0] MASK_IDLE_LEVELS = 16'h7f00;
  // trigger_output_control fields
  localparam int TOC_PRELOAD = 0;
  localparam int TOC_PRELOAD_UPD = 2;
  localparam int TOC_DMA_UPD = 3;
  localparam int TOC_MMS_LSB = 4;
  localparam int TOC_XOR = 7;
  localparam int TOC_IDLE_LSB = 8;
  // slave_trigger_control fields
  localparam int STC_SMS_LSB = 0;
  localparam int STC_TS_LSB = 4;
  localparam int STC_MSM = 7;
  localparam int STC_ETF_LSB = 8;
  localparam int STC_EXT_TRIG_DIVIDER_LSB = 12;
  localparam int STC_ECE = 14;
  localparam int STC_ETP = 15;
  // channel control word: bits 11:0 belong to channels with complementary outputs
  localparam int CHCTRL_W = 16;
  localparam int CHCTRL_COMP_MSB = 11;
  // timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int DEAD_TIME_NS = 40;
  localparam logic [3:0] DEAD_TIME_CYC =
    4'((DEAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  typedef enum logic [2:0] {
    MMS_RESET = 3'b000, MMS_ENABLE = 3'b001, MMS_UPDATE = 3'b010, MMS_PULSE = 3'b011,
    MMS_REF0 = 3'b100, MMS_REF1 = 3'b101, MMS_REF2 = 3'b110, MMS_REF3 = 3'b111
  } master_out_select_t;

  typedef enum logic [2:0] {
    SM_OFF = 3'b000, SM_ENC1 = 3'b001, SM_ENC2 = 3'b010, SM_ENC3 = 3'b011,
    SM_RESET = 3'b100, SM_GATED = 3'b101, SM_TRIGGER = 3'b110, SM_EXTCLK = 3'b111
  } slave_mode_select_t;

  typedef enum logic [2:0] {
    TS_INNER0 = 3'b000, TS_INNER1 = 3'b001, TS_INNER2 = 3'b010, TS_INNER3 = 3'b011,
    TS_IN1_EDGE = 3'b100, TS_IN1_FILT = 3'b101, TS_IN2_FILT = 3'b110, TS_EXT_FILT = 3'b111
  } trigger_select_t;

  // register access request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [15:0] wdata;
  } reg_req_t;

  // transition filter state
  typedef struct packed {
    logic [3:0] cnt;
    logic out;
  } filter_state_t;

  // whole control state
  typedef struct packed {
    logic [15:0] toc;
    logic [15:0] stc;
    logic [15:0] rdata;
    logic [CHCTRL_W-1:0] ctrl_shadow;
    logic [CHCTRL_W-1:0] ctrl_active;
    logic [3:0] dt_cnt;
    logic [3:0] ch_out;
    logic [2:0] ch_comp;
    logic etr_q;
    logic [2:0] pre_cnt;
    logic ext_trig_prescaled;
    logic [4:0] samp_cnt;
    logic ext_trig_filtered_q;
    logic trigger_in_sig_q;
    logic rise_dly;
    logic fall_dly;
    logic in1_q;
    logic in2_q;
    logic trigger_out_sig;
    logic run;
    logic [3:0] dma;
    logic trig_flag;
    logic sw_flag;
    logic tick;
    logic reinit;
    logic start;
    logic cnt_up;
    logic cnt_dn;
    logic tin1;
  } ctrl_state_t;
endpackage

/* hdl/transition_filter.sv */
// digital filter that accepts a transition after a run of equal samples
`timescale 1ns/1ns
module transition_filter
  import timer_sync_pkg::*;
(
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic sample_i,
  input wire logic sig_i,
  input wire logic [3:0] len_i,
  output logic out_o
);
  filter_state_t st_reg;
  filter_state_t st_next;

  // count samples that differ from the output, switch after len_i of them
  always_comb begin
    st_next = st_reg;
    if (sample_i) begin
      if (sig_i == st_reg.out) begin
        st_next.cnt = 4'h0;
      end else if (4'(st_reg.cnt + 4'h1) >= len_i) begin
        st_next.out = sig_i;
        st_next.cnt = 4'h0;
      end else begin
        st_next.cnt = 4'(st_reg.cnt + 4'h1);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign out_o = st_reg.out;
endmodule

/* hdl/timer_trigger_sync_control.sv */
// trigger output, slave mode and external trigger control of a general timer
`timescale 1ns/1ns
module timer_trigger_sync_control
  import timer_sync_pkg::*;
(
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire reg_req_t reg_req_i,
  output logic [15:0] reg_rdata_o,
  input wire logic [1:0] lock_level_i,
  input wire logic main_out_enable_i,
  input wire logic [3:0] chan_drive_i,
  input wire logic [2:0] chan_drive_comp_i,
  output logic [3:0] chan_out_o,
  output logic [2:0] chan_out_comp_o,
  input wire logic [2:0] chan_pin_i,
  output logic timer_in1_o,
  input wire logic in1_any_edge_i,
  input wire logic in1_filtered_i,
  input wire logic in2_filtered_i,
  input wire logic [3:0] inner_trigger_i,
  input wire logic ext_trig_pin_i,
  input wire logic update_generate_bit_i,
  input wire logic counter_run_bit_i,
  input wire logic update_event_i,
  input wire logic chan1_capture_set_i,
  input wire logic [3:0] compare_ref_i,
  input wire logic [3:0] cc_event_i,
  input wire logic switchover_generate_bit_i,
  input wire logic chan_ctrl_wr_i,
  input wire logic [CHCTRL_W-1:0] chan_ctrl_wdata_i,
  input wire logic trigger_flag_clr_i,
  input wire logic switchover_flag_clr_i,
  output logic [CHCTRL_W-1:0] chan_ctrl_o,
  output logic trigger_out_sig_o,
  output logic counter_run_signal_o,
  output logic [3:0] dma_req_o,
  output logic trigger_flag_o,
  output logic switchover_flag_o,
  output logic count_tick_o,
  output logic counter_reinit_o,
  output logic counter_start_o,
  output logic count_up_o,
  output logic count_down_o
);
  ctrl_state_t st_reg;
  ctrl_state_t st_next;
  logic ext_trig_filtered;
  logic sample_en;
  logic [3:0] filt_len;
  logic [5:0] samp_div;

  // sampling divider and run length for each filter code
  function automatic logic [9:0] filter_code(input logic [3:0] code);
    case (code)
      4'h0: filter_code = {6'h01, 4'h1};
      4'h1: filter_code = {6'h01, 4'h2};
      4'h2: filter_code = {6'h01, 4'h4};
      4'h3: filter_code = {6'h01, 4'h8};
      4'h4: filter_code = {6'h02, 4'h6};
      4'h5: filter_code = {6'h02, 4'h8};
      4'h6: filter_code = {6'h04, 4'h6};
      4'h7: filter_code = {6'h04, 4'h8};
      4'h8: filter_code = {6'h08, 4'h6};
      4'h9: filter_code = {6'h08, 4'h8};
      4'ha: filter_code = {6'h10, 4'h5};
      4'hb: filter_code = {6'h10, 4'h6};
      4'hc: filter_code = {6'h10, 4'h8};
      4'hd: filter_code = {6'h20, 4'h5};
      4'he: filter_code = {6'h20, 4'h6};
      default: filter_code = {6'h20, 4'h8};
    endcase
  endfunction

  // filter on the prescaled external trigger
  // filtered external trigger
  transition_filter u_ext_filter (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .sample_i(sample_en),
    .sig_i(st_reg.ext_trig_prescaled),
    .len_i(filt_len),
    .out_o(ext_trig_filtered)
  );

  // next-state logic for the whole block
  always_comb begin
    logic [15:0] w;
    logic locked;
    logic xor_sel;
    logic dma_upd;
    logic preload;
    logic preload_upd;
    logic master_slave_sync;
    logic ece;
    logic [1:0] ext_trig_divider;
    logic [2:0] half;
    master_out_select_t master_out_select;
    slave_mode_select_t slave_mode_select;
    trigger_select_t ts;
    logic etr_pol;
    logic etr_rise;
    logic ext_trig_filtered_rise;
    logic trigger_in_sig;
    logic rise_now;
    logic fall_now;
    logic eff_rise;
    logic eff_fall;
    logic gate_lvl;
    logic e1;
    logic e2;
    logic commut;
    logic [CHCTRL_W-1:0] ctrl_src;
    w = reg_req_i.wdata;
    locked = (lock_level_i != 2'b00);
    xor_sel = st_reg.toc[TOC_XOR];
    dma_upd = st_reg.toc[TOC_DMA_UPD];
    preload = st_reg.toc[TOC_PRELOAD];
    preload_upd = st_reg.toc[TOC_PRELOAD_UPD];
    master_out_select = master_out_select_t'(st_reg.toc[TOC_MMS_LSB +: 3]);
    slave_mode_select = slave_mode_select_t'(st_reg.stc[STC_SMS_LSB +: 3]);
    ts = trigger_select_t'(st_reg.stc[STC_TS_LSB +: 3]);
    master_slave_sync = st_reg.stc[STC_MSM];
    ece = st_reg.stc[STC_ECE];
    ext_trig_divider = st_reg.stc[STC_EXT_TRIG_DIVIDER_LSB +: 2];
    {samp_div, filt_len} = filter_code(st_reg.stc[STC_ETF_LSB +: 4]);
    st_next = st_reg;

    // register writes; idle levels frozen under lock
    if (reg_req_i.wr && reg_req_i.addr == OFS_TRIG_OUT_CTRL) begin
      if (locked) begin
        st_next.toc = ((w & MASK_TRIG_OUT_CTRL) & ~MASK_IDLE_LEVELS) |
                      (st_reg.toc & MASK_IDLE_LEVELS);
      end else begin
        st_next.toc = w & MASK_TRIG_OUT_CTRL;
      end
    end
    if (reg_req_i.wr && reg_req_i.addr == OFS_SLAVE_TRIG_CTRL) begin
      st_next.stc = w & MASK_SLAVE_TRIG_CTRL;
    end
    // register reads, unmapped offsets read zero
    if (reg_req_i.rd) begin
      case (reg_req_i.addr)
        OFS_TRIG_OUT_CTRL: st_next.rdata = st_reg.toc;
        OFS_SLAVE_TRIG_CTRL: st_next.rdata = st_reg.stc;
        default: st_next.rdata = 16'h0000;
      endcase
    end

    st_next.tin1 = xor_sel ? (^chan_pin_i) : chan_pin_i[0];

    etr_pol = ext_trig_pin_i ^ st_reg.stc[STC_ETP];
    etr_rise = etr_pol & ~st_reg.etr_q;
    st_next.etr_q = etr_pol;
    // divide by toggling every 2^(code-1) rising edges
    half = 3'((4'h1 << ext_trig_divider) >> 1) - 3'h1;
    if (ext_trig_divider == 2'b00) begin
      st_next.ext_trig_prescaled = etr_pol;
      st_next.pre_cnt = 3'h0;
    end else if (etr_rise) begin
      if (st_reg.pre_cnt >= half) begin
        st_next.pre_cnt = 3'h0;
        st_next.ext_trig_prescaled = ~st_reg.ext_trig_prescaled;
      end else begin
        st_next.pre_cnt = 3'(st_reg.pre_cnt + 3'h1);
      end
    end
    // sample strobe at the coded rate
    sample_en = (6'(st_reg.samp_cnt) >= 6'(samp_div - 6'h01));
    st_next.samp_cnt = sample_en ? 5'h00 : 5'(st_reg.samp_cnt + 5'h01);
    ext_trig_filtered_rise = ext_trig_filtered & ~st_reg.ext_trig_filtered_q;
    st_next.ext_trig_filtered_q = ext_trig_filtered;

    case (ts)
      TS_INNER0: trigger_in_sig = inner_trigger_i[0];
      TS_INNER1: trigger_in_sig = inner_trigger_i[1];
      TS_INNER2: trigger_in_sig = inner_trigger_i[2];
      TS_INNER3: trigger_in_sig = inner_trigger_i[3];
      TS_IN1_EDGE: trigger_in_sig = in1_any_edge_i;
      TS_IN1_FILT: trigger_in_sig = in1_filtered_i;
      TS_IN2_FILT: trigger_in_sig = in2_filtered_i;
      default: trigger_in_sig = ext_trig_filtered;
    endcase
    rise_now = trigger_in_sig & ~st_reg.trigger_in_sig_q;
    fall_now = ~trigger_in_sig & st_reg.trigger_in_sig_q;
    st_next.trigger_in_sig_q = trigger_in_sig;
    st_next.rise_dly = rise_now;
    st_next.fall_dly = fall_now;
    // one cycle of delay so slaves act on the same edge
    eff_rise = master_slave_sync ? st_reg.rise_dly : rise_now;
    eff_fall = master_slave_sync ? st_reg.fall_dly : fall_now;
    gate_lvl = master_slave_sync ? st_reg.trigger_in_sig_q : trigger_in_sig;

    // slave mode controller
    e1 = in1_filtered_i ^ st_reg.in1_q;
    e2 = in2_filtered_i ^ st_reg.in2_q;
    st_next.in1_q = in1_filtered_i;
    st_next.in2_q = in2_filtered_i;
    st_next.tick = 1'b0;
    st_next.reinit = 1'b0;
    st_next.start = 1'b0;
    st_next.cnt_up = 1'b0;
    st_next.cnt_dn = 1'b0;
    case (slave_mode_select)
      // quadrature counting on one or both inputs
      SM_ENC1: begin
        st_next.cnt_up = counter_run_bit_i & e2 & (in2_filtered_i != in1_filtered_i);
        st_next.cnt_dn = counter_run_bit_i & e2 & (in2_filtered_i == in1_filtered_i);
      end
      SM_ENC2: begin
        st_next.cnt_up = counter_run_bit_i & e1 & (in1_filtered_i == in2_filtered_i);
        st_next.cnt_dn = counter_run_bit_i & e1 & (in1_filtered_i != in2_filtered_i);
      end
      SM_ENC3: begin
        st_next.cnt_up = counter_run_bit_i & ((e2 & (in2_filtered_i != in1_filtered_i)) |
                                              (e1 & (in1_filtered_i == in2_filtered_i)));
        st_next.cnt_dn = counter_run_bit_i & ((e2 & (in2_filtered_i == in1_filtered_i)) |
                                              (e1 & (in1_filtered_i != in2_filtered_i)));
      end
      // reset, gated, trigger and external clock modes
      SM_RESET: begin
        st_next.tick = counter_run_bit_i;
        st_next.reinit = eff_rise;
      end
      SM_GATED: st_next.tick = counter_run_bit_i & gate_lvl;
      SM_TRIGGER: begin
        st_next.tick = counter_run_bit_i;
        st_next.start = eff_rise;
      end
      SM_EXTCLK: st_next.tick = counter_run_bit_i & eff_rise;
      default: st_next.tick = counter_run_bit_i;
    endcase
    // external clock mode 2 takes the clock
    if (ece) begin
      st_next.tick = counter_run_bit_i & ext_trig_filtered_rise;
    end

    st_next.run = counter_run_bit_i | ((slave_mode_select == SM_GATED) & gate_lvl);
    // trigger flag, set wins over clear
    st_next.trig_flag = ((slave_mode_select != SM_OFF) &
                         ((slave_mode_select == SM_GATED) ? (eff_rise | eff_fall) : eff_rise)) |
                        (st_reg.trig_flag & ~trigger_flag_clr_i);

    // master trigger output
    case (master_out_select)
      // software update, or slave reset one cycle late
      MMS_RESET: st_next.trigger_out_sig = update_generate_bit_i | st_reg.reinit;
      MMS_ENABLE: st_next.trigger_out_sig = st_next.run;
      MMS_UPDATE: st_next.trigger_out_sig = update_event_i;
      MMS_PULSE: st_next.trigger_out_sig = chan1_capture_set_i;
      default: st_next.trigger_out_sig = compare_ref_i[master_out_select[1:0]];
    endcase

    st_next.dma = dma_upd ? {4{update_event_i}} : cc_event_i;

    ctrl_src = chan_ctrl_wr_i ? chan_ctrl_wdata_i : st_reg.ctrl_shadow;
    if (chan_ctrl_wr_i) begin
      st_next.ctrl_shadow = chan_ctrl_wdata_i;
      st_next.ctrl_active[CHCTRL_W-1:CHCTRL_COMP_MSB+1] =
        chan_ctrl_wdata_i[CHCTRL_W-1:CHCTRL_COMP_MSB+1];
      if (!preload) begin
        st_next.ctrl_active = chan_ctrl_wdata_i;
      end
    end
    commut = preload & (switchover_generate_bit_i | (preload_upd & eff_rise));
    if (commut) begin
      st_next.ctrl_active[CHCTRL_COMP_MSB:0] = ctrl_src[CHCTRL_COMP_MSB:0];
    end
    // switchover flag, set wins over clear
    st_next.sw_flag = commut | (st_reg.sw_flag & ~switchover_flag_clr_i);

    // idle levels after dead-time while outputs are off
    if (main_out_enable_i) begin
      st_next.dt_cnt = DEAD_TIME_CYC;
      st_next.ch_out = chan_drive_i;
      st_next.ch_comp = chan_drive_comp_i;
    end else if (st_reg.dt_cnt != 4'h0) begin
      st_next.dt_cnt = 4'(st_reg.dt_cnt - 4'h1);
      st_next.ch_out = {st_reg.toc[TOC_IDLE_LSB+6], 3'b000};
      st_next.ch_comp = 3'b000;
    end else begin
      st_next.ch_out = {st_reg.toc[TOC_IDLE_LSB+6], st_reg.toc[TOC_IDLE_LSB+4],
                        st_reg.toc[TOC_IDLE_LSB+2], st_reg.toc[TOC_IDLE_LSB]};
      st_next.ch_comp = {st_reg.toc[TOC_IDLE_LSB+5], st_reg.toc[TOC_IDLE_LSB+3],
                         st_reg.toc[TOC_IDLE_LSB+1]};
    end
  end

  // state register, all fields clear at reset
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs straight from the state register
  assign reg_rdata_o = st_reg.rdata;
  assign chan_out_o = st_reg.ch_out;
  assign chan_out_comp_o = st_reg.ch_comp;
  assign timer_in1_o = st_reg.tin1;
  assign chan_ctrl_o = st_reg.ctrl_active;
  assign trigger_out_sig_o = st_reg.trigger_out_sig;
  assign counter_run_signal_o = st_reg.run;
  assign dma_req_o = st_reg.dma;
  assign trigger_flag_o = st_reg.trig_flag;
  assign switchover_flag_o = st_reg.sw_flag;
  assign count_tick_o = st_reg.tick;
  assign counter_reinit_o = st_reg.reinit;
  assign counter_start_o = st_reg.start;
  assign count_up_o = st_reg.cnt_up;
  assign count_down_o = st_reg.cnt_dn;

  // checks on the block's own behaviour
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);

  sequence s_outputs_off;
    !main_out_enable_i [*8] ##1 !main_out_enable_i [*4];
  endsequence

  a_idle_after_dt: assert property (
    s_outputs_off |=> chan_out_o == $past({st_reg.toc[14], st_reg.toc[12], st_reg.toc[10],
                                           st_reg.toc[8]}) &&
                      chan_out_comp_o == $past({st_reg.toc[13], st_reg.toc[11],
                                                st_reg.toc[9]}))
    else $error("outputs not at idle levels after dead-time");

  a_idle_lock_hold: assert property (
    (reg_req_i.wr && reg_req_i.addr == OFS_TRIG_OUT_CTRL && lock_level_i != 2'b00)
    |=> st_reg.toc[14:8] == $past(st_reg.toc[14:8]))
    else $error("idle levels changed under lock");

  a_in1_select: assert property (
    ##1 timer_in1_o == ($past(st_reg.toc[7]) ? (^$past(chan_pin_i)) : $past(chan_pin_i[0])))
    else $error("input 1 source wrong");

  a_trigger_out_sig_update: assert property (
    (st_reg.toc[6:4] == 3'b010 && update_event_i) |=> trigger_out_sig_o)
    else $error("update not sent on trigger output");

  a_trigger_out_sig_ref: assert property (
    (st_reg.toc[6] && compare_ref_i[st_reg.toc[5:4]]) |=> trigger_out_sig_o)
    else $error("compare reference not routed");

  a_dma_select: assert property (
    (st_reg.toc[3] && !update_event_i) |=> dma_req_o == 4'h0)
    else $error("dma request without update event");

  a_commut_flag: assert property (
    (st_reg.toc[0] && switchover_generate_bit_i) |=> switchover_flag_o ##0
    chan_ctrl_o[11:0] == $past(chan_ctrl_wr_i ? chan_ctrl_wdata_i[11:0] :
                               st_reg.ctrl_shadow[11:0]))
    else $error("commutation did not load controls");

  a_trig_flag_set: assert property (
    (st_reg.stc[7:0] == 8'h55 && in1_filtered_i != st_reg.trigger_in_sig_q) |=> trigger_flag_o)
    else $error("trigger flag not set on trigger edge");

  a_ext_clock2: assert property (
    (st_reg.stc[14] && counter_run_bit_i && ext_trig_filtered && !st_reg.ext_trig_filtered_q)
    |=> count_tick_o)
    else $error("external clock edge not counted");

  a_gated_run: assert property (
    (st_reg.stc[2:0] == 3'b101 && !st_reg.stc[7] && in1_filtered_i &&
     st_reg.stc[6:4] == 3'b101) |=> counter_run_signal_o)
    else $error("gated trigger did not drive counter-run");
endmodule

/* testbench/sibling_timer_model.sv */
// model of the sibling timers and the external trigger source
`timescale 1ns/1ns
module sibling_timer_model (
  input wire logic clk_i,
  input wire logic [3:0] fire_i,
  input wire logic ext_i,
  output logic [3:0] inner_trigger_o,
  output logic ext_trig_pin_o
);
  logic [1:0] hold_reg;
  initial begin
    inner_trigger_o = 4'h0;
    ext_trig_pin_o = 1'b0;
    hold_reg = 2'h0;
  end
  always @(posedge clk_i) begin
    inner_trigger_o <= fire_i;
    hold_reg <= hold_reg + 2'h1;
    if (hold_reg == 2'h3) begin
      ext_trig_pin_o <= ext_i; // pin moves once every 4 cycles
    end
  end
endmodule

/* testbench/timer_trigger_sync_control_tb.sv */
// self-checking bench of the trigger and slave control
`timescale 1ns/1ns
module timer_trigger_sync_control_tb;
  import timer_sync_pkg::*;
  logic clk, resetn, main_out_enable, ext, run, upd, swg, cwr, tclr, sclr, saw;
  reg_req_t req;
  logic [1:0] lock;
  logic [2:0] drvc, pins, coutc;
  logic [3:0] drv, fire, cref, cce, cout, itrig, dma;
  logic [15:0] cwd, rdata, cctl, v;
  logic tin1, epin, trigger_out_sig, crun, tflag, sflag, tick, reinit, start, up, dn;
  logic f1, ug, cap;
  int failures, checks_done;
  int codes[5] = '{1, 4, 5, 6, 7};
  sibling_timer_model i_sibling_timer_model (.clk_i(clk), .fire_i(fire), .ext_i(ext),
    .inner_trigger_o(itrig), .ext_trig_pin_o(epin));
  timer_trigger_sync_control i_timer_trigger_sync_control (.clk_i(clk), .resetn_i(resetn),
    .reg_req_i(req), .reg_rdata_o(rdata), .lock_level_i(lock), .main_out_enable_i(main_out_enable),
    .chan_drive_i(drv), .chan_drive_comp_i(drvc), .chan_out_o(cout), .chan_out_comp_o(coutc),
    .chan_pin_i(pins), .timer_in1_o(tin1), .in1_any_edge_i(1'b0), .in1_filtered_i(f1),
    .in2_filtered_i(1'b0), .inner_trigger_i(itrig), .ext_trig_pin_i(epin),
    .update_generate_bit_i(ug), .counter_run_bit_i(run), .update_event_i(upd),
    .chan1_capture_set_i(cap), .compare_ref_i(cref), .cc_event_i(cce),
    .switchover_generate_bit_i(swg), .chan_ctrl_wr_i(cwr), .chan_ctrl_wdata_i(cwd),
    .trigger_flag_clr_i(tclr), .switchover_flag_clr_i(sclr), .chan_ctrl_o(cctl),
    .trigger_out_sig_o(trigger_out_sig), .counter_run_signal_o(crun), .dma_req_o(dma),
    .trigger_flag_o(tflag), .switchover_flag_o(sflag), .count_tick_o(tick),
    .counter_reinit_o(reinit), .counter_start_o(start), .count_up_o(up), .count_down_o(dn));
  // expected trigger output for level sources
  function automatic logic trigger_out_sig_exp(int k, logic r, logic [3:0] c);
    return (k == 1) ? r : c[k - 4];
  endfunction
  // expected idle outputs, channels then complements
  function automatic logic [6:0] idle_exp(logic [15:0] t);
    return {t[14], t[12], t[10], t[8], t[13], t[11], t[9]};
  endfunction
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    req <= '{1'b1, 1'b0, a, d};
    @(posedge clk);
    req <= '0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge clk);
    req <= '{1'b0, 1'b1, a, 16'h0};
    @(posedge clk);
    req <= '0;
    #1 chk("rdata", e, rdata);
  endtask
  task automatic results();
    $display("failures %0d checks_done %0d", failures, checks_done);
    if (failures == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // clock and watchdog
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    #40000;
    failures++;
    results();
  end
  // main sequence
  initial begin
    void'($urandom(83480));
    req = '0;
    resetn = 1'b0;
    {lock, main_out_enable, ext, run, upd, swg, cwr, tclr, sclr, drv, drvc, pins, fire, cref, cce, cwd} = '0;
    {f1, ug, cap} = 3'b000;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    rd(OFS_TRIG_OUT_CTRL, RST_TRIG_OUT_CTRL);
    rd(OFS_SLAVE_TRIG_CTRL, RST_SLAVE_TRIG_CTRL);
    repeat (4) begin
      v = 16'($urandom) & 16'hfff8;
      wr(OFS_SLAVE_TRIG_CTRL, v);
      rd(OFS_SLAVE_TRIG_CTRL, v & MASK_SLAVE_TRIG_CTRL);
      wr(8'h0c, v);
      rd(8'h0c, 16'h0000);
    end
    @(posedge clk);
    lock <= 2'h1 + 2'($urandom_range(2));
    wr(OFS_TRIG_OUT_CTRL, MASK_IDLE_LEVELS);
    rd(OFS_TRIG_OUT_CTRL, 16'h0000);
    @(posedge clk);
    lock <= 2'h0;
    v = 16'($urandom) & MASK_IDLE_LEVELS;
    wr(OFS_TRIG_OUT_CTRL, v);
    main_out_enable <= 1'b1;
    drv <= 4'($urandom);
    drvc <= 3'($urandom);
    cyc(4);
    chk("chan_run", {9'h0, drv, drvc}, {9'h0, cout, coutc});
    @(posedge clk);
    main_out_enable <= 1'b0;
    cyc(4);
    chk("chan_dead", {9'h0, v[14], 6'h0}, {9'h0, cout, coutc});
    cyc(DEAD_TIME_CYC + 2);
    chk("chan_idle", {9'h0, idle_exp(v)}, {9'h0, cout, coutc});
    for (int x = 0; x < 2; x++) begin
      wr(OFS_TRIG_OUT_CTRL, 16'(x) << TOC_XOR);
      pins <= 3'($urandom);
      cyc(4);
      chk("timer_in1", {15'h0, x ? ^pins : pins[0]}, {15'h0, tin1});
    end
    foreach (codes[i]) begin
      wr(OFS_TRIG_OUT_CTRL, 16'(codes[i]) << TOC_MMS_LSB);
      run <= 1'($urandom);
      cref <= 4'($urandom);
      cyc(4);
      chk("trigger_out_sig_level", {15'h0, trigger_out_sig_exp(codes[i], run, cref)}, {15'h0, trigger_out_sig});
      chk("cnt_run", {15'h0, run}, {15'h0, crun});
    end
    wr(OFS_TRIG_OUT_CTRL, 16'(MMS_UPDATE) << TOC_MMS_LSB);
    upd <= 1'b1;
    @(posedge clk);
    upd <= 1'b0;
    #1 chk("trigger_out_sig_upd", 16'h1, {15'h0, trigger_out_sig});
    cyc(1);
    chk("trigger_out_sig_end", 16'h0, {15'h0, trigger_out_sig});
    for (int p = 0; p < 2; p++) begin
      wr(OFS_TRIG_OUT_CTRL, 16'(3 * p) << TOC_MMS_LSB);
      if (p == 0) ug <= 1'b1;
      else cap <= 1'b1;
      @(posedge clk);
      {ug, cap} <= 2'b00;
      #1 chk("trigger_out_sig_pulse", 16'h1, {15'h0, trigger_out_sig});
      cyc(1);
      chk("trigger_out_sig_pulse_end", 16'h0, {15'h0, trigger_out_sig});
    end
    for (int s = 0; s < 2; s++) begin
      wr(OFS_TRIG_OUT_CTRL, 16'(s) << TOC_DMA_UPD);
      v = 16'($urandom) & 16'h000f;
      cce <= v[3:0];
      @(posedge clk);
      cce <= 4'h0;
      #1 chk("dma_req", s ? 16'h0 : v, {12'h0, dma});
    end
    wr(OFS_TRIG_OUT_CTRL, 16'h0001);
    cwd <= 16'($urandom) | 16'h0001;
    cwr <= 1'b1;
    @(posedge clk);
    cwr <= 1'b0;
    cyc(3);
    chk("ctrl_held", 16'h0, {4'h0, cctl[11:0]});
    @(posedge clk);
    swg <= 1'b1;
    @(posedge clk);
    swg <= 1'b0;
    cyc(2);
    chk("ctrl_load", cwd, cctl);
    chk("sw_flag", 16'h1, {15'h0, sflag});
    @(posedge clk);
    sclr <= 1'b1;
    @(posedge clk);
    sclr <= 1'b0;
    cyc(2);
    chk("sw_clear", 16'h0, {15'h0, sflag});
    // reset slave mode: inner triggers 0..2 and the external trigger each give reinit and the trigger flag
    foreach (codes[i]) begin
      v = 16'(codes[i] == 1 ? 0 : codes[i] - 4 + 4 * (codes[i] == 7)) << STC_TS_LSB;
      wr(OFS_SLAVE_TRIG_CTRL, 16'h0000);
      wr(OFS_SLAVE_TRIG_CTRL, v);
      wr(OFS_SLAVE_TRIG_CTRL, v | 16'(SM_RESET) | (16'($urandom_range(1)) << STC_MSM));
      tclr <= 1'b1;
      @(posedge clk);
      tclr <= 1'b0;
      saw = 1'b0;
      if (v[6:4] == 3'h7) ext <= 1'b1;
      else fire <= 4'h1 << v[5:4];
      repeat (14) begin
        @(posedge clk);
        #1 saw |= reinit;
      end
      chk("reinit", 16'h1, {15'h0, saw});
      chk("trig_flag", 16'h1, {15'h0, tflag});
      @(posedge clk);
      fire <= 4'h0;
      ext <= 1'b0;
    end
    // gated mode on filtered input 1: counter-run follows the level, the flag sets on both edges
    wr(OFS_SLAVE_TRIG_CTRL, 16'h0000);
    wr(OFS_SLAVE_TRIG_CTRL, 16'(TS_IN1_FILT) << STC_TS_LSB);
    wr(OFS_SLAVE_TRIG_CTRL, (16'(TS_IN1_FILT) << STC_TS_LSB) | 16'(SM_GATED));
    run <= 1'b0;
    for (int g = 1; g >= 0; g--) begin
      @(posedge clk);
      {f1, tclr} <= {1'(g), 1'b1};
      @(posedge clk);
      tclr <= 1'b0;
      cyc(3);
      chk("gate_run", 16'(g), {15'h0, crun});
      chk("gate_flag", 16'h1, {15'h0, tflag});
    end
    results();
  end
endmodule
